// ===== ihc_defines.svh
// Offsets, field positions, reset values and codes of the header codec.
// Assumes inclusion by bare name; definitions only.
`ifndef IHC_DEFINES_SVH
`define IHC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define IHC_OFS_CTRL    8'h00
`define IHC_OFS_FRAG    8'h04
`define IHC_OFS_ORIG_LO 8'h08
`define IHC_OFS_ORIG_HI 8'h0C
`define IHC_OFS_STAT    8'h10
`define IHC_OFS_MASK    8'h14
`define IHC_OFS_RXINFO  8'h18

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define IHC_C_FMT   1:0
`define IHC_C_FRAG  2
`define IHC_C_RELAY 3
`define IHC_C_HOP   7:4
`define IHC_C_KIND  9:8
`define IHC_CTRL_RST 10'h000
`define IHC_FRAG_RST 16'h0100
`define IHC_ST_W    5

// ----------------------------------------------------------------
// Header constants
// ----------------------------------------------------------------
`define IHC_VERSION   4'h1
`define IHC_HEADER_OCTET_COUNT_BASE 8'h03
`define IHC_HEADER_OCTET_COUNT_FRAG 8'h05
`define IHC_HEADER_OCTET_COUNT_FIX  8'h06
`define IHC_MARKER    8'hFF
`define IHC_KIND_BAD  2'h3
`define IHC_F_OLDVER  2'h0
`define IHC_F_BADVER  2'h1
`define IHC_F_MALF    2'h2
`define IHC_OKAY      2'h0
`define IHC_SLVERR    2'h2

`endif

// ===== ihc_pkg.sv
// Types shared by the header codec.
// Assumes nothing of its surroundings.
`default_nettype none

package ihc_pkg;
	typedef enum logic [2:0] {
		IHC_T_IDLE  = 3'b000,
		IHC_T_CALC  = 3'b001,
		IHC_T_HDR   = 3'b010,
		IHC_T_ORIG  = 3'b011,
		IHC_T_DWAIT = 3'b100,
		IHC_T_DEMIT = 3'b101,
		IHC_T_PAY   = 3'b110
	} ihc_tx_st_t;

	typedef enum logic [1:0] {
		IHC_R_HDR  = 2'b00,
		IHC_R_PAY  = 2'b01,
		IHC_R_DROP = 2'b10
	} ihc_rx_st_t;

	typedef enum logic [1:0] {
		IHC_A1 = 2'b00,
		IHC_A4 = 2'b01,
		IHC_A6 = 2'b10
	} ihc_afmt_t;
endpackage

`default_nettype wire

// ===== ihc_codec.sv
// Header builder and checker for intranet data packets, AXI4-Lite regs.
// Assumes upper layer and link framing are logic on the same clock.
//
// Notes on behaviour
// - Mandatory four fields always built and required.
// - Fragmenting adds message id and fragment fields.
// - Relaying adds id, hops, originator, destination entries.
// - Only UI, I or DIA units carry packets.
// - Octet0 type high nibble, version low; length next.
// - Version one in every built header.
// - Version zero peers classified unsupported, no malfunction.
// - Wrong version packets dropped, payload withheld.
// - Wrong version raises fault with source, type, version.
// - Address fields one, five or seven octets.
// - Entry count bounded by length and format.
// - Sender splits; receiver indicates after last fragment.
// - Length counts header octets: 3, 5, 9+.
// - Message type is four bits, 0 to 15.
// - Message id is eight bits from originator.
`timescale 1ns/1ps
`default_nettype none
`include "ihc_defines.svh"

module ihc_codec #(
	parameter int LEN_W    = 16,
	parameter int MAX_DEST = 15
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [7:0]       awaddr,
	input  wire logic             awvalid,
	output logic                  awready,
	input  wire logic [31:0]      wdata,
	input  wire logic [3:0]       wstrb,
	input  wire logic             wvalid,
	output logic                  wready,
	output logic [1:0]            bresp,
	output logic                  bvalid,
	input  wire logic             bready,
	input  wire logic [7:0]       araddr,
	input  wire logic             arvalid,
	output logic                  arready,
	output logic [31:0]           rdata,
	output logic [1:0]            rresp,
	output logic                  rvalid,
	input  wire logic             rready,
	output logic                  irq,
	input  wire logic             send_request,
	output logic                  send_ready,
	input  wire logic [3:0]       req_type,
	input  wire logic [7:0]       req_service,
	input  wire logic [7:0]       req_msg_id,
	input  wire logic [LEN_W-1:0] req_length,
	input  wire logic [3:0]       req_dest_count,
	input  wire logic             dst_valid,
	output logic                  dst_ready,
	input  wire logic [7:0]       dst_status,
	input  wire logic [47:0]      dst_addr,
	input  wire logic             pl_valid,
	output logic                  pl_ready,
	input  wire logic [7:0]       pl_data,
	output logic                  lk_tx_valid,
	input  wire logic             lk_tx_ready,
	output logic [7:0]            lk_tx_data,
	output logic                  lk_tx_last,
	output logic [1:0]            lk_tx_kind,
	input  wire logic             lk_rx_valid,
	output logic                  lk_rx_ready,
	input  wire logic [7:0]       lk_rx_data,
	input  wire logic             lk_rx_last,
	input  wire logic [1:0]       lk_rx_kind,
	input  wire logic [47:0]      lk_rx_src,
	output logic                  up_valid,
	input  wire logic             up_ready,
	output logic [7:0]            up_data,
	output logic                  up_last,
	output logic                  delivery_indication,
	output logic [3:0]            dlv_type,
	output logic [7:0]            dlv_msg_id,
	output logic [47:0]           dlv_src,
	output logic                  fault_indication,
	output logic [1:0]            flt_code,
	output logic [3:0]            flt_type,
	output logic [3:0]            flt_version,
	output logic [47:0]           flt_src
);
	import ihc_pkg::*;

	if (LEN_W < 8 || LEN_W > 16 || MAX_DEST < 1 || MAX_DEST > 15) begin : g_chk
		$error("ihc_codec: unsupported parameter values");
	end

	// ----------------------------------------------------------------
	// Address helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] alen(input logic [1:0] f);
		alen = (f == IHC_A4) ? 8'h05 : (f == IHC_A6) ? 8'h07 : 8'h01;
	endfunction

	function automatic logic [7:0] aoct(input logic [47:0] a,
		input logic [1:0] f, input logic [7:0] k);
		logic [2:0] i;
		i = 3'(alen(f) - 8'h01 - k);
		if (alen(f) == 8'h01) aoct = a[7:0];
		else if (k == 8'h00) aoct = `IHC_MARKER;
		else aoct = a[{i, 3'b000} +: 8];
	endfunction

	function automatic logic [47:0] amask(input logic [47:0] a,
		input logic [1:0] f);
		amask = (f == IHC_A6) ? a : (f == IHC_A4) ? {16'h0, a[31:0]}
			: {40'h0, a[7:0]};
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			o[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
		end
		wmerge = o;
	endfunction

	// ----------------------------------------------------------------
	// Register file and bus slave
	// ----------------------------------------------------------------
	logic             aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0]       aw_q, next_aw_q;
	logic [31:0]      w_q, next_w_q, wv;
	logic [3:0]       ws_q, next_ws_q;
	logic [9:0]       ctrl, next_ctrl;
	logic [LEN_W-1:0] fsize, next_fsize;
	logic [47:0]      orig, next_orig;
	logic [4:0]       stat, next_stat, mask, next_mask, ev;
	logic             next_awready, next_wready, next_bvalid, next_arready;
	logic             next_rvalid, next_irq;
	logic [1:0]       next_bresp, next_rresp;
	logic [31:0]      next_rdata;
	logic [7:0]       r_header_octet_count, next_r_header_octet_count;
	logic [3:0]       r_type, next_r_type, r_ver, next_r_ver;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_q    = aw_q;
		next_w_q     = w_q;
		next_ws_q    = ws_q;
		next_ctrl    = ctrl;
		next_fsize   = fsize;
		next_orig    = orig;
		next_mask    = mask;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		next_stat    = stat | ev;
		wv = w_q;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_q    = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_q    = wdata;
			next_ws_q   = wstrb;
		end
		if (bvalid && bready) next_bvalid = 1'b0;
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = `IHC_OKAY;
			case (aw_q)
			`IHC_OFS_CTRL: next_ctrl = 10'(wmerge({22'h0, ctrl}, w_q, ws_q));
			`IHC_OFS_FRAG: begin
				wv = wmerge({{(32-LEN_W){1'b0}}, fsize}, w_q, ws_q);
				next_fsize = wv[LEN_W-1:0];
			end
			`IHC_OFS_ORIG_LO: next_orig[31:0] = wmerge(orig[31:0], w_q, ws_q);
			`IHC_OFS_ORIG_HI: begin
				wv = wmerge({16'h0, orig[47:32]}, w_q, ws_q);
				next_orig[47:32] = wv[15:0];
			end
			`IHC_OFS_STAT: if (ws_q[0])
				next_stat = (stat & ~w_q[4:0]) | ev;
			`IHC_OFS_MASK: next_mask = 5'(wmerge({27'h0, mask}, w_q, ws_q));
			`IHC_OFS_RXINFO: ;
			default: next_bresp = `IHC_SLVERR;
			endcase
		end
		if (rvalid && rready) next_rvalid = 1'b0;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp  = `IHC_OKAY;
			case (araddr)
			`IHC_OFS_CTRL:    next_rdata = {22'h0, ctrl};
			`IHC_OFS_FRAG:    next_rdata = {{(32-LEN_W){1'b0}}, fsize};
			`IHC_OFS_ORIG_LO: next_rdata = orig[31:0];
			`IHC_OFS_ORIG_HI: next_rdata = {16'h0, orig[47:32]};
			`IHC_OFS_STAT:    next_rdata = {27'h0, stat};
			`IHC_OFS_MASK:    next_rdata = {27'h0, mask};
			`IHC_OFS_RXINFO:  next_rdata = {16'h0, r_header_octet_count, r_type, r_ver};
			default: begin
				next_rdata = 32'h0000_0000;
				next_rresp = `IHC_SLVERR;
			end
			endcase
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
		next_irq     = |(next_stat & next_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_q    <= 8'h00;
			w_q     <= 32'h0000_0000;
			ws_q    <= 4'h0;
			ctrl    <= `IHC_CTRL_RST;
			fsize   <= LEN_W'(`IHC_FRAG_RST);
			orig    <= 48'h0;
			stat    <= 5'h00;
			mask    <= 5'h00;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `IHC_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `IHC_OKAY;
			irq     <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_q    <= next_aw_q;
			w_q     <= next_w_q;
			ws_q    <= next_ws_q;
			ctrl    <= next_ctrl;
			fsize   <= next_fsize;
			orig    <= next_orig;
			stat    <= next_stat;
			mask    <= next_mask;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
			irq     <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// Header builder
	// ----------------------------------------------------------------
	ihc_tx_st_t       tst, next_tst;
	logic [7:0]       hidx, next_hidx, t_id, next_t_id, t_svc, next_t_svc;
	logic [7:0]       ent_st, next_ent_st, al, hl, eo;
	logic [3:0]       t_type, next_t_type, t_ndst, next_t_ndst;
	logic [3:0]       dleft, next_dleft, fnum, next_fnum, ftot, next_ftot;
	logic [3:0]       t_hop, next_t_hop;
	logic [1:0]       t_fmt, next_t_fmt, next_kind;
	logic             t_fe, next_t_fe, t_re, next_t_re, em, el, free;
	logic [LEN_W-1:0] rem, next_rem, tmp, next_tmp, fcnt, next_fcnt;
	logic [47:0]      ent_ad, next_ent_ad;
	logic             next_tx_valid, next_tx_last, ev_done, ev_ref;
	logic [7:0]       next_tx_data;

	always_comb begin
		next_tst = tst;      next_hidx = hidx;     next_t_id = t_id;
		next_t_svc = t_svc;  next_ent_st = ent_st; next_t_type = t_type;
		next_t_ndst = t_ndst; next_dleft = dleft;  next_fnum = fnum;
		next_ftot = ftot;    next_t_hop = t_hop;   next_t_fmt = t_fmt;
		next_t_fe = t_fe;    next_t_re = t_re;     next_rem = rem;
		next_tmp = tmp;      next_fcnt = fcnt;     next_ent_ad = ent_ad;
		next_kind = lk_tx_kind;
		next_tx_data = lk_tx_data;
		next_tx_last = lk_tx_last;
		next_tx_valid = lk_tx_valid && !lk_tx_ready;
		free = !lk_tx_valid || lk_tx_ready;
		em = 1'b0;
		el = 1'b0;
		eo = 8'h00;
		ev_done = 1'b0;
		ev_ref = 1'b0;
		al = alen(t_fmt);
		hl = !t_re ? (t_fe ? `IHC_HEADER_OCTET_COUNT_FRAG : `IHC_HEADER_OCTET_COUNT_BASE)
			: `IHC_HEADER_OCTET_COUNT_FIX + al + {4'h0, t_ndst} * (al + 8'h01);
		case (tst)
		IHC_T_IDLE: if (send_request && send_ready) begin
			next_t_type = req_type;
			next_t_svc  = req_service;
			next_t_id   = req_msg_id;
			next_t_ndst = req_dest_count;
			next_t_fmt  = ctrl[`IHC_C_FMT];
			next_t_fe   = ctrl[`IHC_C_FRAG];
			next_t_re   = ctrl[`IHC_C_RELAY];
			next_t_hop  = ctrl[`IHC_C_HOP];
			next_kind   = ctrl[`IHC_C_KIND];
			next_tmp    = req_length;
			next_rem    = req_length;
			next_ftot   = 4'h1;
			if (req_length == '0 || ctrl[`IHC_C_KIND] == `IHC_KIND_BAD
				|| (ctrl[`IHC_C_RELAY] && (req_dest_count == 4'h0
				|| 32'(req_dest_count) > MAX_DEST)))
				ev_ref = 1'b1;
			else
				next_tst = IHC_T_CALC;
		end
		IHC_T_CALC: if (t_fe && tmp > fsize) begin
			if (ftot == 4'hF) begin
				ev_ref = 1'b1;
				next_tst = IHC_T_IDLE;
			end else begin
				next_tmp = tmp - fsize;
				next_ftot = ftot + 4'h1;
			end
		end else begin
			next_tst = IHC_T_HDR;
			next_hidx = 8'h00;
			next_fnum = 4'h1;
			next_fcnt = '0;
		end
		IHC_T_HDR: if (free) begin
			em = 1'b1;
			next_hidx = hidx + 8'h01;
			case (hidx)
			8'h00: eo = {t_type, `IHC_VERSION};
			8'h01: eo = hl;
			8'h02: eo = t_svc;
			8'h03: eo = t_id;
			8'h04: eo = {fnum, ftot};
			default: eo = {4'h0, t_hop};
			endcase
			if ((hidx == 8'h02 && !t_fe && !t_re) || (hidx == 8'h04 && !t_re))
				next_tst = IHC_T_PAY;
			else if (hidx == 8'h05) begin
				next_tst = IHC_T_ORIG;
				next_hidx = 8'h00;
			end
		end
		IHC_T_ORIG: if (free) begin
			em = 1'b1;
			eo = aoct(orig, t_fmt, hidx);
			next_hidx = hidx + 8'h01;
			if (hidx == al - 8'h01) begin
				next_tst = IHC_T_DWAIT;
				next_dleft = t_ndst;
			end
		end
		IHC_T_DWAIT: if (dst_valid && dst_ready) begin
			next_ent_st = dst_status;
			next_ent_ad = dst_addr;
			next_hidx = 8'h00;
			next_tst = IHC_T_DEMIT;
		end
		IHC_T_DEMIT: if (free) begin
			em = 1'b1;
			eo = (hidx == 8'h00) ? ent_st
				: aoct(ent_ad, t_fmt, hidx - 8'h01);
			next_hidx = hidx + 8'h01;
			if (hidx == al) begin
				next_dleft = dleft - 4'h1;
				next_tst = (dleft == 4'h1) ? IHC_T_PAY : IHC_T_DWAIT;
			end
		end
		IHC_T_PAY: if (pl_valid && pl_ready) begin
			em = 1'b1;
			eo = pl_data;
			next_rem = rem - LEN_W'(1);
			next_fcnt = fcnt + LEN_W'(1);
			el = (rem == LEN_W'(1)) || (t_fe && next_fcnt == fsize);
			if (rem == LEN_W'(1)) begin
				ev_done = 1'b1;
				next_tst = IHC_T_IDLE;
			end else if (el) begin
				next_fnum = fnum + 4'h1;
				next_fcnt = '0;
				next_hidx = 8'h00;
				next_tst = IHC_T_HDR;
			end
		end
		default: next_tst = IHC_T_IDLE;
		endcase
		if (em) begin
			next_tx_valid = 1'b1;
			next_tx_data = eo;
			next_tx_last = el;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tst <= IHC_T_IDLE;  hidx <= 8'h00;  t_id <= 8'h00;
			t_svc <= 8'h00;     ent_st <= 8'h00; t_type <= 4'h0;
			t_ndst <= 4'h0;     dleft <= 4'h0;  fnum <= 4'h0;
			ftot <= 4'h0;       t_hop <= 4'h0;  t_fmt <= 2'h0;
			t_fe <= 1'b0;       t_re <= 1'b0;   rem <= '0;
			tmp <= '0;          fcnt <= '0;     ent_ad <= 48'h0;
			lk_tx_valid <= 1'b0; lk_tx_data <= 8'h00; lk_tx_last <= 1'b0;
			lk_tx_kind <= 2'h0; send_ready <= 1'b0;
			dst_ready <= 1'b0;  pl_ready <= 1'b0;
		end else begin
			tst <= next_tst;    hidx <= next_hidx; t_id <= next_t_id;
			t_svc <= next_t_svc; ent_st <= next_ent_st;
			t_type <= next_t_type; t_ndst <= next_t_ndst;
			dleft <= next_dleft; fnum <= next_fnum; ftot <= next_ftot;
			t_hop <= next_t_hop; t_fmt <= next_t_fmt;
			t_fe <= next_t_fe;  t_re <= next_t_re; rem <= next_rem;
			tmp <= next_tmp;    fcnt <= next_fcnt; ent_ad <= next_ent_ad;
			lk_tx_valid <= next_tx_valid; lk_tx_data <= next_tx_data;
			lk_tx_last <= next_tx_last;   lk_tx_kind <= next_kind;
			send_ready <= (next_tst == IHC_T_IDLE);
			dst_ready <= (next_tst == IHC_T_DWAIT);
			pl_ready <= (next_tst == IHC_T_PAY) && !next_tx_valid;
		end
	end

	// ----------------------------------------------------------------
	// Header checker
	// ----------------------------------------------------------------
	ihc_rx_st_t  rst, next_rst;
	logic [7:0]  ridx, next_ridx, r_id, next_r_id, r_frag, next_r_frag;
	logic [7:0]  ents, next_ents, rel, ral, hln;
	logic [2:0]  epos, next_epos;
	logic [47:0] r_orig, next_r_orig, r_src, next_r_src, sel;
	logic        beat, hend, malf, sok, ev_dlv, ev_bad, ev_malf;
	logic        next_up_valid, next_up_last, next_dlv, next_flt;
	logic [7:0]  next_up_data;
	logic [1:0]  next_fcode;

	always_comb begin
		next_rst = rst;     next_ridx = ridx;   next_r_id = r_id;
		next_r_frag = r_frag; next_ents = ents; next_epos = epos;
		next_r_orig = r_orig; next_r_src = r_src; next_r_header_octet_count = r_header_octet_count;
		next_r_type = r_type; next_r_ver = r_ver;
		next_up_valid = up_valid && !up_ready;
		next_up_data = up_data;
		next_up_last = up_last;
		next_dlv = 1'b0;
		next_flt = 1'b0;
		next_fcode = flt_code;
		ev_dlv = 1'b0;
		ev_bad = 1'b0;
		ev_malf = 1'b0;
		beat = lk_rx_valid && lk_rx_ready;
		ral = alen(ctrl[`IHC_C_FMT]);
		rel = ridx - `IHC_HEADER_OCTET_COUNT_FIX;
		hln = (ridx == 8'h01) ? lk_rx_data : r_header_octet_count;
		hend = (ridx >= 8'h02) && (ridx + 8'h01 == hln);
		case (rst)
		IHC_R_HDR: if (beat) begin
			next_ridx = ridx + 8'h01;
			case (ridx)
			8'h00: begin
				next_r_type = lk_rx_data[7:4];
				next_r_ver = lk_rx_data[3:0];
				next_r_src = lk_rx_src;
				next_r_frag = 8'h00;
				next_r_orig = 48'h0;
				next_ents = 8'h00;
				next_epos = 3'h0;
			end
			8'h01: next_r_header_octet_count = lk_rx_data;
			8'h02: ;
			8'h03: next_r_id = lk_rx_data;
			8'h04: next_r_frag = lk_rx_data;
			8'h05: ;
			default: if (rel < ral)
				next_r_orig = {r_orig[39:0], lk_rx_data};
			else if (8'(epos) == ral) begin
				next_epos = 3'h0;
				next_ents = ents + 8'h01;
			end else
				next_epos = epos + 3'h1;
			endcase
			sok = hln == `IHC_HEADER_OCTET_COUNT_BASE || hln == `IHC_HEADER_OCTET_COUNT_FRAG
				|| (hln > `IHC_HEADER_OCTET_COUNT_FIX && next_ents != 8'h00
				&& next_epos == 3'h0);
			malf = (ridx == 8'h00 && lk_rx_kind == `IHC_KIND_BAD)
				|| (ridx == 8'h01 && lk_rx_data < `IHC_HEADER_OCTET_COUNT_BASE)
				|| (hend && !sok) || (lk_rx_last && !hend);
			sel = (hln > `IHC_HEADER_OCTET_COUNT_FIX)
				? amask(next_r_orig, ctrl[`IHC_C_FMT]) : next_r_src;
			if (malf || (hend && next_r_ver != `IHC_VERSION)) begin
				next_flt = 1'b1;
				ev_malf = malf;
				ev_bad = !malf;
				next_fcode = malf ? `IHC_F_MALF
					: (next_r_ver == 4'h0) ? `IHC_F_OLDVER
					: `IHC_F_BADVER;
				next_rst = lk_rx_last ? IHC_R_HDR : IHC_R_DROP;
				next_ridx = 8'h00;
			end else if (hend) begin
				next_rst = lk_rx_last ? IHC_R_HDR : IHC_R_PAY;
				next_ridx = 8'h00;
				next_dlv = lk_rx_last;
			end
		end
		IHC_R_PAY: if (beat) begin
			next_up_valid = 1'b1;
			next_up_data = lk_rx_data;
			next_up_last = lk_rx_last;
			if (lk_rx_last) begin
				next_rst = IHC_R_HDR;
				next_dlv = (r_frag[7:4] == r_frag[3:0]);
			end
		end
		IHC_R_DROP: if (beat && lk_rx_last)
			next_rst = IHC_R_HDR;
		default: next_rst = IHC_R_HDR;
		endcase
		ev_dlv = next_dlv;
		if (!beat || rst != IHC_R_HDR) begin
			sok = 1'b0;
			malf = 1'b0;
			sel = (r_header_octet_count > `IHC_HEADER_OCTET_COUNT_FIX)
				? amask(r_orig, ctrl[`IHC_C_FMT]) : r_src;
		end
	end

	assign ev = {ev_ref, ev_malf, ev_bad, ev_dlv, ev_done};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst <= IHC_R_HDR;   ridx <= 8'h00;  r_id <= 8'h00;
			r_frag <= 8'h00;    ents <= 8'h00;  epos <= 3'h0;
			r_orig <= 48'h0;    r_src <= 48'h0; r_header_octet_count <= 8'h00;
			r_type <= 4'h0;     r_ver <= 4'h0;
			up_valid <= 1'b0;   up_data <= 8'h00; up_last <= 1'b0;
			lk_rx_ready <= 1'b0;
			delivery_indication <= 1'b0; fault_indication <= 1'b0;
			dlv_type <= 4'h0;   dlv_msg_id <= 8'h00; dlv_src <= 48'h0;
			flt_code <= 2'h0;   flt_type <= 4'h0; flt_version <= 4'h0;
			flt_src <= 48'h0;
		end else begin
			rst <= next_rst;    ridx <= next_ridx; r_id <= next_r_id;
			r_frag <= next_r_frag; ents <= next_ents; epos <= next_epos;
			r_orig <= next_r_orig; r_src <= next_r_src;
			r_header_octet_count <= next_r_header_octet_count; r_type <= next_r_type;
			r_ver <= next_r_ver;
			up_valid <= next_up_valid; up_data <= next_up_data;
			up_last <= next_up_last;
			lk_rx_ready <= !next_up_valid;
			delivery_indication <= next_dlv;
			fault_indication <= next_flt;
			if (next_dlv) begin
				dlv_type <= next_r_type;
				dlv_msg_id <= next_r_id;
				dlv_src <= sel;
			end
			if (next_flt) begin
				flt_code <= next_fcode;
				flt_type <= next_r_type;
				flt_version <= next_r_ver;
				flt_src <= sel;
			end
		end
	end

endmodule

`default_nettype wire

// ===== ihc_checker.sv
// Port checker for the header codec.
// Assumes binding onto ihc_codec.
`timescale 1ns/1ps
`default_nettype none
module ihc_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       lk_tx_valid,
	input wire logic       lk_tx_ready,
	input wire logic [7:0] lk_tx_data,
	input wire logic [1:0] lk_tx_kind,
	input wire logic       lk_tx_last,
	input wire logic       pl_ready,
	input wire logic       up_valid,
	input wire logic       up_ready,
	input wire logic [7:0] up_data,
	input wire logic       delivery_indication,
	input wire logic       fault_indication,
	input wire logic [1:0] flt_code,
	input wire logic [3:0] flt_version
);
	logic first;
	logic next_first;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_comb begin
		next_first = first;
		if (lk_tx_valid && lk_tx_ready)
			next_first = lk_tx_last;
	end
	always_ff @(posedge aclk)
		first <= aresetn ? next_first : 1'b1;
	a_hdr_version: assert property (
		lk_tx_valid && first |-> lk_tx_data[3:0] == 4'h1) else $error("ver");
	a_tx_kind_ok: assert property (
		lk_tx_valid |-> lk_tx_kind != 2'h3) else $error("kind");
	a_tx_hold: assert property (
		lk_tx_valid && !lk_tx_ready |=> lk_tx_valid && $stable(lk_tx_data))
		else $error("tx hold");
	a_old_ver: assert property (
		fault_indication && flt_code == 2'h0 |-> flt_version == 4'h0)
		else $error("old ver");
	a_bad_ver: assert property (
		fault_indication && flt_code == 2'h1 |-> flt_version != 4'h1)
		else $error("bad ver");
	a_drop_nodlv: assert property (
		fault_indication |-> !delivery_indication) else $error("drop");
	a_up_hold: assert property (
		up_valid && !up_ready |=> up_valid && $stable(up_data))
		else $error("up hold");
	a_pay_after: assert property (
		pl_ready |-> !lk_tx_valid) else $error("pl");
endmodule
bind ihc_codec ihc_checker u_chk (.*);
`default_nettype wire

// ===== ihc_link_model.sv
// Link-side model: stalls tx, sends rx units.
// Assumes the codec clock.
`timescale 1ns/1ps
`default_nettype none
module ihc_link_model (
	input wire logic    aclk,
	input wire logic    slow,
	output logic        lk_tx_ready,
	input wire logic    lk_rx_ready,
	output logic        lk_rx_valid,
	output logic [7:0]  lk_rx_data,
	output logic        lk_rx_last,
	output logic [1:0]  lk_rx_kind,
	output logic [47:0] lk_rx_src
);
	logic [7:0] d = 8'h00;
	logic       l = 1'b0;
	initial lk_rx_valid = 1'b0;
	initial lk_tx_ready = 1'b0;
	logic [1:0] kd = 2'h0;
	assign lk_rx_kind = kd;
	assign lk_rx_src = 48'h0000_0000_005A;
	assign lk_rx_data = lk_rx_valid ? d : ~d;
	assign lk_rx_last = lk_rx_valid ? l : ~l;
	always @(posedge aclk)
		lk_tx_ready <= slow ? 1'($urandom) : 1'b1;
	task automatic put(input logic [7:0] b[$], input logic [1:0] k);
		kd <= k;
		foreach (b[i]) begin
			lk_rx_valid <= 1'b1;
			d <= b[i];
			l <= i == b.size() - 1;
			do @(posedge aclk); while (!lk_rx_ready);
		end
		lk_rx_valid <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the header codec.
// Assumes ihc_codec, ihc_link_model and ihc_checker.
`timescale 1ns/1ps
`default_nettype none
`include "ihc_defines.svh"
module testbench;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, send_request = 0, pl_valid = 0;
	logic up_ready = 0, slow = 0, dst_valid = 0;
	logic [7:0] awaddr = 0, araddr = 0, req_service = 0, req_msg_id = 0;
	logic [7:0] pl_data = 0, dst_status = 0, s, id, p [2];
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0, req_type = 0, req_dest_count = 0, t;
	logic [15:0] req_length = 0;
	logic [47:0] dst_addr = 0, dlv_src, flt_src, lk_rx_src;
	logic awready, wready, bvalid, arready, rvalid, irq, send_ready;
	logic dst_ready, pl_ready, lk_tx_valid, lk_tx_ready, lk_tx_last;
	logic lk_rx_valid, lk_rx_ready, lk_rx_last, up_valid, up_last;
	logic delivery_indication, fault_indication;
	logic [1:0] bresp, rresp, lk_tx_kind, lk_rx_kind, flt_code, c;
	logic [31:0] rdata;
	logic [7:0] lk_tx_data, lk_rx_data, up_data, dlv_msg_id, b[$];
	logic [3:0] dlv_type, flt_type, flt_version;
	logic [3:0] rv [5] = '{1, 0, 2, 1, 1};
	logic [7:0] rh [5] = '{3, 3, 3, 2, 3};
	logic [63:0] qr[$], qt[$], qu[$], qi[$];
	int n_fail = 0, tests_run = 0;
	ihc_codec dut (.*);
	ihc_link_model lnk (.*);
	always #50 aclk = ~aclk;
	always @(posedge aclk) up_ready <= 1'($urandom);
	task chk(input logic [63:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		{awaddr, wdata, wstrb} <= {a, d, 4'hF};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		qr.push_back(e);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
	endtask
	task snd(input logic [15:0] n);
		{req_type, req_service, req_msg_id, req_length} <= {t, s, id, n};
		send_request <= 1;
		do @(posedge aclk); while (!send_ready);
		send_request <= 0;
		for (int i = 0; i < n; i++) begin
			{pl_data, pl_valid} <= {p[i], 1'b1};
			do @(posedge aclk); while (!pl_ready);
		end
		pl_valid <= 0;
	endtask
	task wrap_up;
		$display("checks %0d fails %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge aclk) begin
		if (rvalid && rready) chk({rresp, rdata}, qr.pop_front());
		if (lk_tx_valid && lk_tx_ready) chk({lk_tx_kind, lk_tx_last,
			lk_tx_data}, qt.pop_front());
		if (up_valid && up_ready) chk({up_last, up_data}, qu.pop_front());
		if (delivery_indication) chk({2'h3, dlv_type, 4'h0, dlv_src[7:0]},
			qi.pop_front());
		if (fault_indication) chk({flt_code, flt_code == 2'h2 ? 8'h0 :
			{flt_type, flt_version}, flt_src[7:0]}, qi.pop_front());
	end
	initial begin
		#3000000;
		n_fail++;
		wrap_up;
	end
	initial begin
		void'($urandom(37084));
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		slow <= 1;
		rd(`IHC_OFS_FRAG, 34'h100);
		rd(8'h1C, {2'h2, 32'h0});
		wr(`IHC_OFS_FRAG, 32'h1);
		$display("regs done");
		for (int k = 0; k < 3; k++) begin
			wr(`IHC_OFS_CTRL, 32'((k << 8) | (k == 1 ? 4 : 0)));
			{t, s, id, p[0], p[1]} = 36'($urandom) ^ 36'($urandom) << 4;
			for (int i = 0; i < 2; i++) begin
				if (i == 0 || k == 1) begin
					qt.push_back({k[1:0], 1'b0, t, 4'h1});
					qt.push_back({k[1:0], 1'b0, 8'(k == 1 ? 5 : 3)});
					qt.push_back({k[1:0], 1'b0, s});
					if (k == 1) qt.push_back({2'h1, 1'b0, id});
					if (k == 1) qt.push_back({3'h2, 4'(i + 1), 4'h2});
				end
				qt.push_back({k[1:0], 1'(k == 1 || i == 1), p[i]});
			end
			snd(2);
			while (qt.size()) @(posedge aclk);
		end
		snd(0);
		$display("tx done");
		for (int j = 0; j < 5; j++) begin
			{t, p[0]} = 12'($urandom);
			b = '{{t, rv[j]}, rh[j], 8'h00, p[0]};
			c = rh[j] != 3 || j == 4 ? 2'h2 : rv[j] == 0 ? 2'h0 : 2'h1;
			if (c == 2'h1 && rv[j] == 1) begin
				qu.push_back({1'b1, p[0]});
				qi.push_back({2'h3, t, 4'h0, lk_rx_src[7:0]});
			end else
				qi.push_back({c, c == 2 ? 8'h0 : {t, rv[j]}, lk_rx_src[7:0]});
			lnk.put(b, j == 4 ? 2'h3 : 2'h0);
			while (qi.size() || qu.size()) @(posedge aclk);
		end
		$display("rx done");
		rd(`IHC_OFS_STAT, 34'h1F);
		chk(irq, 0);
		wr(`IHC_OFS_MASK, 32'h4);
		repeat (2) @(posedge aclk);
		chk(irq, 1);
		wr(`IHC_OFS_STAT, 32'h4);
		rd(`IHC_OFS_STAT, 34'h1B);
		repeat (2) @(posedge aclk);
		chk(irq, 0);
		$display("irq done");
		chk(qt.size() + qu.size() + qi.size(), 0);
		wrap_up;
	end
endmodule
`default_nettype wire
